// File: src/ssf_top.v
// ssf_top: synchronous serial port slave (spi or i2c) with its read-only status register
// assumes: pins arrive asynchronously; the register port is synchronous to clock
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "ssf_map.vh"

module ssf_top (
  input  wire       clock,
  input  wire       rst_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        irq,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire       sck_in,
  input  wire       sdi_in,
  input  wire       ss_n_in,
  output reg        sdo_out,
  output reg        sdo_oe
);

  // address compare: header bits only, or the whole byte for a 10-bit low address
  function addr_match;
    input [7:0] rx;
    input [7:0] own_addr;
    input       full;
    begin
      addr_match = full ? (rx == own_addr) : (rx[7:1] == own_addr[7:1]);
    end
  endfunction

  wire [`SSF_PIN_W-1:0] pins;
  reg  [`SSF_PIN_W-1:0] pins_prev_reg;

  reg [7:0] ctrl_reg;
  reg [7:0] saddr_reg;
  reg [7:0] buf_reg;
  reg [7:0] irq_st_reg;
  reg [7:0] irq_mask_reg;
  reg [7:0] rx_shift_reg;
  reg [7:0] tx_shift_reg;
  reg [3:0] bit_cnt_reg;
  reg [1:0] addr_left_reg;
  reg       bf_reg;
  reg       da_reg;
  reg       stop_reg;
  reg       start_reg;
  reg       rw_reg;
  reg       ua_reg;
  reg       active_reg;
  reg       addressed_reg;
  reg       tx_mode_reg;
  reg       ack_pend_reg;
  reg [7:0] status_next;
  reg [7:0] rdata_next;

  ssf_pin_sync u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .pin_in   ({ss_n_in, sdi_in, sck_in, sda_in, scl_in}),
    .pin_filt (pins)
  );

  // mode decode and pin edges, all on filtered pin levels
  wire en       = ctrl_reg[`SSF_CTL_EN];
  wire i2c      = ctrl_reg[`SSF_CTL_I2C];
  wire ten      = ctrl_reg[`SSF_CTL_TEN];
  wire scl      = pins[`SSF_PIN_SCL];
  wire sda      = pins[`SSF_PIN_SDA];
  wire sck      = pins[`SSF_PIN_SCK];
  wire ssn      = pins[`SSF_PIN_SSN];
  wire scl_rise = scl & ~pins_prev_reg[`SSF_PIN_SCL];
  wire scl_fall = ~scl & pins_prev_reg[`SSF_PIN_SCL];
  wire scl_high = scl & pins_prev_reg[`SSF_PIN_SCL];
  wire sda_rise = sda & ~pins_prev_reg[`SSF_PIN_SDA];
  wire sda_fall = ~sda & pins_prev_reg[`SSF_PIN_SDA];
  wire sck_rise = sck & ~pins_prev_reg[`SSF_PIN_SCK];
  wire sck_fall = ~sck & pins_prev_reg[`SSF_PIN_SCK];

  // bus conditions: data moving while the clock line stays high
  wire i2c_on    = en & i2c;
  wire spi_on    = en & ~i2c & ~ssn;
  wire start_det = i2c_on & scl_high & sda_fall;
  wire stop_det  = i2c_on & scl_high & sda_rise;

  // byte completion on the eighth clock edge of either mode
  wire       i2c_bit  = i2c_on & active_reg & ~start_det & ~stop_det & scl_rise;
  wire       i2c_done = i2c_bit & (bit_cnt_reg == `SSF_LAST_BIT);
  wire       spi_done = spi_on & sck_rise & (bit_cnt_reg == `SSF_LAST_BIT);
  wire [7:0] rx_byte  = {rx_shift_reg[6:0], i2c ? sda : pins[`SSF_PIN_SDI]};

  // address phase: a 10-bit header with the read bit set ends the phase early
  wire addr_phase = (addr_left_reg != `SSF_ADDR_NONE);
  wire addr_full  = ten & (addr_left_reg == `SSF_ADDR_ONE);
  wire addr_final = (addr_left_reg == `SSF_ADDR_ONE) | (ten & rx_byte[0]);
  wire addr_hit   = i2c_done & addr_phase & addr_match(rx_byte, saddr_reg, addr_full);

  // a full buffer refuses a new data byte; only a matched address byte still overwrites unread data
  wire rx_store = ~bf_reg & (spi_done | (i2c_done & ~addr_phase & addressed_reg & ~rw_reg));
  wire tx_done  = i2c_done & tx_mode_reg;
  wire buf_wr   = reg_wr & (reg_addr == `SSF_OFF_BUF);
  wire buf_rd   = reg_rd & (reg_addr == `SSF_OFF_BUF);

  // buffer-full: set wins over clear so a byte landing during a read is kept
  wire bf_set = rx_store | addr_hit | (buf_wr & i2c_on & tx_mode_reg);
  wire bf_clr = buf_rd | tx_done;

  // interrupt events and write-one-to-clear
  wire [7:0] irq_ev  = {5'h00, stop_det, start_det, rx_store | addr_hit | tx_done};
  wire       ist_wr  = reg_wr & (reg_addr == `SSF_OFF_IRQ_ST);
  wire [7:0] ist_clr = ist_wr ? (reg_wdata & `SSF_IRQ_WMASK) : `SSF_RST_BYTE;

  // status view: i2c-only bits read zero outside i2c mode, top bits always zero
  always @* begin
    status_next                = `SSF_RST_BYTE;
    status_next[`SSF_ST_DA]    = i2c & da_reg;
    status_next[`SSF_ST_STOP]  = i2c & stop_reg;
    status_next[`SSF_ST_START] = i2c & start_reg;
    status_next[`SSF_ST_RW]    = i2c & rw_reg;
    status_next[`SSF_ST_UA]    = i2c & ua_reg;
    status_next[`SSF_ST_BF]    = bf_reg;
  end

  // read mux; an unmapped address answers zero
  always @* begin
    case (reg_addr)
      `SSF_OFF_STATUS:   rdata_next = status_next;
      `SSF_OFF_CTRL:     rdata_next = ctrl_reg;
      `SSF_OFF_BUF:      rdata_next = buf_reg;
      `SSF_OFF_SADDR:    rdata_next = saddr_reg;
      `SSF_OFF_IRQ_ST:   rdata_next = irq_st_reg;
      `SSF_OFF_IRQ_MASK: rdata_next = irq_mask_reg;
      default:           rdata_next = `SSF_RST_BYTE;
    endcase
  end

  // register port, flags and interrupt output
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata     <= `SSF_RST_BYTE;
      irq           <= 1'b0;
      ctrl_reg      <= `SSF_RST_BYTE;
      saddr_reg     <= `SSF_RST_BYTE;
      irq_st_reg    <= `SSF_RST_BYTE;
      irq_mask_reg  <= `SSF_RST_BYTE;
      bf_reg        <= 1'b0;
      ua_reg        <= 1'b0;
      pins_prev_reg <= `SSF_PIN_IDLE;
    end else begin
      pins_prev_reg <= pins;
      reg_rdata     <= reg_rd ? rdata_next : `SSF_RST_BYTE;
      if (reg_wr && reg_addr == `SSF_OFF_CTRL) begin
        ctrl_reg <= reg_wdata & `SSF_CTL_WMASK;
      end
      if (reg_wr && reg_addr == `SSF_OFF_SADDR) begin
        saddr_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `SSF_OFF_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata & `SSF_IRQ_WMASK;
      end
      bf_reg     <= bf_set | (bf_reg & ~bf_clr);
      irq_st_reg <= irq_ev | (irq_st_reg & ~ist_clr);
      irq        <= |((irq_ev | (irq_st_reg & ~ist_clr)) & irq_mask_reg);
      // 10-bit: every matched address byte asks for an address rewrite
      ua_reg     <= (addr_hit & ten) |
                    (ua_reg & ~(reg_wr && reg_addr == `SSF_OFF_SADDR));
    end
  end

  // serial engine for both modes; disabling the port parks it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buf_reg       <= `SSF_RST_BYTE;
      rx_shift_reg  <= `SSF_RST_BYTE;
      tx_shift_reg  <= `SSF_RST_BYTE;
      bit_cnt_reg   <= `SSF_BIT_RST;
      addr_left_reg <= `SSF_ADDR_NONE;
      da_reg        <= 1'b0;
      stop_reg      <= 1'b0;
      start_reg     <= 1'b0;
      rw_reg        <= 1'b0;
      active_reg    <= 1'b0;
      addressed_reg <= 1'b0;
      tx_mode_reg   <= 1'b0;
      ack_pend_reg  <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
      sdo_out       <= 1'b0;
      sdo_oe        <= 1'b0;
    end else begin
      sdo_oe <= spi_on;
      // a byte moves to the buffer first; the flags follow from bf_set
      if (rx_store | addr_hit) begin
        buf_reg <= rx_byte;
      end else if (buf_wr) begin
        buf_reg <= reg_wdata;
      end
      if (!en) begin
        start_reg     <= 1'b0;
        stop_reg      <= 1'b0;
        bit_cnt_reg   <= `SSF_BIT_RST;
        active_reg    <= 1'b0;
        addressed_reg <= 1'b0;
        tx_mode_reg   <= 1'b0;
        addr_left_reg <= `SSF_ADDR_NONE;
        sda_oe        <= 1'b0;
        if (buf_wr) begin
          tx_shift_reg <= reg_wdata;
        end
      end else if (i2c) begin
        if (buf_wr) begin
          tx_shift_reg <= reg_wdata;
        end
        if (start_det) begin
          // also a repeated start: address phase begins again
          start_reg     <= 1'b1;
          stop_reg      <= 1'b0;
          rw_reg        <= 1'b0;
          active_reg    <= 1'b1;
          addressed_reg <= 1'b0;
          tx_mode_reg   <= 1'b0;
          bit_cnt_reg   <= `SSF_BIT_RST;
          addr_left_reg <= ten ? `SSF_ADDR_TWO : `SSF_ADDR_ONE;
          sda_oe        <= 1'b0;
        end else if (stop_det) begin
          stop_reg      <= 1'b1;
          start_reg     <= 1'b0;
          rw_reg        <= 1'b0;
          active_reg    <= 1'b0;
          addressed_reg <= 1'b0;
          tx_mode_reg   <= 1'b0;
          addr_left_reg <= `SSF_ADDR_NONE;
          sda_oe        <= 1'b0;
        end else if (i2c_bit) begin
          if (bit_cnt_reg == `SSF_ACK_SLOT) begin
            // ack clock: a master nack ends a read transfer
            bit_cnt_reg <= `SSF_BIT_RST;
            if (tx_mode_reg && sda) begin
              tx_mode_reg <= 1'b0;
            end
          end else begin
            rx_shift_reg <= rx_byte;
            bit_cnt_reg  <= bit_cnt_reg + `SSF_BIT_STEP;
            if (i2c_done) begin
              ack_pend_reg <= addr_hit | rx_store;
              if (addr_phase) begin
                da_reg <= 1'b0;
                if (!addr_hit) begin
                  addr_left_reg <= `SSF_ADDR_NONE;
                end else if (addr_final) begin
                  addr_left_reg <= `SSF_ADDR_NONE;
                  addressed_reg <= 1'b1;
                  rw_reg        <= rx_byte[0];
                  tx_mode_reg   <= rx_byte[0];
                end else begin
                  addr_left_reg <= `SSF_ADDR_ONE;
                end
              end else if (addressed_reg) begin
                da_reg <= 1'b1;
              end
            end
          end
        end else if (i2c_on && active_reg && scl_fall) begin
          // change sda only on a scl fall, holding it through scl high: ack slot, else next transmit bit
          if (bit_cnt_reg == `SSF_ACK_SLOT) begin
            sda_oe <= ack_pend_reg;
          end else if (tx_mode_reg) begin
            sda_oe       <= ~tx_shift_reg[7];
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
          end else begin
            sda_oe <= 1'b0;
          end
        end
      end else begin
        // spi slave: sample on sck rise, change sdo on sck fall, msb first
        sda_oe <= 1'b0;
        if (ssn) begin
          bit_cnt_reg <= `SSF_BIT_RST;
          if (buf_wr) begin
            tx_shift_reg <= reg_wdata;
            sdo_out      <= reg_wdata[7];
          end
        end else if (sck_rise) begin
          rx_shift_reg <= rx_byte;
          bit_cnt_reg  <= spi_done ? `SSF_BIT_RST : bit_cnt_reg + `SSF_BIT_STEP;
        end else if (sck_fall) begin
          sdo_out      <= tx_shift_reg[6];
          tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end else if (buf_wr && bit_cnt_reg == `SSF_BIT_RST) begin
          // a write mid-byte is ignored so the shifting word stays whole
          tx_shift_reg <= reg_wdata;
          sdo_out      <= reg_wdata[7];
        end
      end
    end
  end

endmodule // ssf_top

// File: src/ssf_map.vh
// ssf_map.vh: register offsets, field positions, reset values and counts
// assumes: included by bare name into every design file of the status block
`ifndef SSF_MAP_VH
`define SSF_MAP_VH

// register offsets on the 8-bit register port
`define SSF_OFF_STATUS   8'h94
`define SSF_OFF_CTRL     8'h14
`define SSF_OFF_BUF      8'h13
`define SSF_OFF_SADDR    8'h93
`define SSF_OFF_IRQ_ST   8'h95
`define SSF_OFF_IRQ_MASK 8'h96

// serial_port_status fields
`define SSF_ST_DA    5
`define SSF_ST_STOP  4
`define SSF_ST_START 3
`define SSF_ST_RW    2
`define SSF_ST_UA    1
`define SSF_ST_BF    0

// serial_port_control fields
`define SSF_CTL_EN    5
`define SSF_CTL_I2C   0
`define SSF_CTL_TEN   1
`define SSF_CTL_WMASK 8'h23

// interrupt status and mask fields
`define SSF_IRQ_BYTE  0
`define SSF_IRQ_START 1
`define SSF_IRQ_STOP  2
`define SSF_IRQ_WMASK 8'h07

// reset values and counts
`define SSF_RST_BYTE   8'h00
`define SSF_BIT_RST    4'h0
`define SSF_LAST_BIT   4'h7
`define SSF_ACK_SLOT   4'h8
`define SSF_BIT_STEP   4'h1
`define SSF_ADDR_NONE  2'h0
`define SSF_ADDR_ONE   2'h1
`define SSF_ADDR_TWO   2'h2

// pin vector layout {ss_n, sdi, sck, sda, scl} and its idle level
`define SSF_PIN_W    5
`define SSF_PIN_SCL  0
`define SSF_PIN_SDA  1
`define SSF_PIN_SCK  2
`define SSF_PIN_SDI  3
`define SSF_PIN_SSN  4
`define SSF_PIN_IDLE 5'h13

`endif

// File: src/ssf_pin_sync.v
// ssf_pin_sync: three-flop synchroniser with agreement filter for pin inputs
// assumes: pins are asynchronous to clock; output follows a pin once stages two and three agree
`timescale 1ns/1ps
`include "ssf_map.vh"

module ssf_pin_sync (
  input  wire                   clock,
  input  wire                   rst_n,
  input  wire [`SSF_PIN_W-1:0]  pin_in,
  output reg  [`SSF_PIN_W-1:0]  pin_filt
);

  reg [`SSF_PIN_W-1:0] stage1_reg;
  reg [`SSF_PIN_W-1:0] stage2_reg;
  reg [`SSF_PIN_W-1:0] stage3_reg;
  integer              i;

  // stage one feeds only stage two, so no logic sees a metastable value
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= `SSF_PIN_IDLE;
      stage2_reg <= `SSF_PIN_IDLE;
      stage3_reg <= `SSF_PIN_IDLE;
      pin_filt   <= `SSF_PIN_IDLE;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      for (i = 0; i < `SSF_PIN_W; i = i + 1) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          pin_filt[i] <= stage3_reg[i];
        end
      end
    end
  end

endmodule // ssf_pin_sync

// File: verif/ssf_top_checker.sv
// ssf_top_checker: port-level properties of the serial status block
// assumes: bound to ssf_top; control and mask writes are shadowed here from the register port
`timescale 1ns/1ps
`include "ssf_map.vh"

module ssf_top_checker (
  input wire       clock,
  input wire       rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       irq,
  input wire       scl_in,
  input wire       sda_oe,
  input wire       ss_n_in,
  input wire       sdo_oe
);
  reg [7:0] ctl_q, ctl_d, msk_q, msk_d;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // shadows kept two deep so a value just written has surely taken effect
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {msk_d, msk_q, ctl_d, ctl_q} <= 32'h00000000;
    end else begin
      ctl_q <= (reg_wr && reg_addr == `SSF_OFF_CTRL) ? reg_wdata : ctl_q;
      msk_q <= (reg_wr && reg_addr == `SSF_OFF_IRQ_MASK) ? reg_wdata : msk_q;
      {msk_d, ctl_d} <= {msk_q, ctl_q};
    end
  end
  sequence st_rd;
    reg_rd && reg_addr == `SSF_OFF_STATUS;
  endsequence
  sequence spi_mode;
    !ctl_q[`SSF_CTL_I2C] && !ctl_d[`SSF_CTL_I2C];
  endsequence
  sequence port_off;
    !ctl_q[`SSF_CTL_EN] && !ctl_d[`SSF_CTL_EN];
  endsequence
  chk_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  chk_top_zero: assert property (st_rd |=> reg_rdata[7:6] == 2'h0)
    else $error("status top bits not zero");
  chk_spi_bits: assert property (st_rd ##0 spi_mode |=> reg_rdata[5:1] == 5'h00)
    else $error("i2c-only status bits set in spi mode");
  chk_off_flags: assert property (st_rd ##0 port_off |=> reg_rdata[4:3] == 2'h0)
    else $error("start or stop flag set while disabled");
  chk_cond_excl: assert property (st_rd |=> !(reg_rdata[4] && reg_rdata[3]))
    else $error("start and stop flags both set");
  chk_oe_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda driven while scl high");
  chk_sdo_idle: assert property (ss_n_in [*8] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  chk_irq_masked: assert property (msk_q[2:0] == 3'h0 && msk_d[2:0] == 3'h0 |-> !irq)
    else $error("irq high with all events masked");
endmodule // ssf_top_checker

bind ssf_top ssf_top_checker chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .scl_in(scl_in), .sda_oe(sda_oe),
  .ss_n_in(ss_n_in), .sdo_oe(sdo_oe));

// File: verif/ssf_link_master.sv
// ssf_link_master: behavioural spi and i2c master on the pins of the status block
// assumes: sda merged with a pull-up by the bench; link clocks move only inside frames
`timescale 1ns/1ps

module ssf_link_master (
  input  wire sda,
  input  wire sdo,
  output reg  scl,
  output reg  sda_m,
  output reg  sck,
  output reg  sdi,
  output reg  ss_n
);
  localparam real HALF = 62.5; // half of the 125 ns link period
  integer   i;
  reg [8:0] fr;
  // idle: i2c lines released high, spi clock low, deselected
  initial {scl, sda_m, sck, sdi, ss_n} = 5'h19;
  // one spi byte msb first; sdi flips after the frame so no stale bit looks held
  task spi_byte(input [7:0] tx, output [7:0] rx);
    begin
      ss_n = 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
        sdi = tx[i];
        #HALF sck = 1'b1;
        rx[i] = sdo;
        #HALF sck = 1'b0;
      end
      #HALF ss_n = 1'b1;
      sdi = ~sdi;
    end
  endtask
  task i2c_start;
    begin
      #HALF sda_m = 1'b0;
      #HALF scl = 1'b0;
    end
  endtask
  task i2c_stop;
    begin
      #10 sda_m = 1'b0;
      #HALF scl = 1'b1;
      #HALF sda_m = 1'b1;
      #HALF;
    end
  endtask
  // eight bits and the ninth clock; hold stretches the ninth high time so firmware can act
  task i2c_byte(input [7:0] tx, input mack, input integer hold, output ack, output [7:0] rx);
    begin
      fr = {tx, ~mack};
      for (i = 8; i >= 0; i = i - 1) begin
        #10 sda_m = fr[i];
        #HALF scl = 1'b1;
        fr[i] = sda;
        if (i == 0) #(hold);
        #HALF scl = 1'b0;
      end
      ack = ~fr[0];
      rx = fr[8:1];
    end
  endtask
endmodule // ssf_link_master

// File: verif/test_sync_serial_status_flags.sv
// test_sync_serial_status_flags: register-level tests of the status block under spi and i2c traffic
// assumes: ssf_link_master drives the pins; sda is open drain with a pull-up merged here
`timescale 1ns/1ps
`include "ssf_map.vh"

module test_sync_serial_status_flags;
  reg        clock = 1'b0;
  reg        rst_n = 1'b0;
  reg  [7:0] reg_addr = 8'h00;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire       irq, scl, sda_m, sda_out, sda_oe, sck, sdi, ss_n, sdo_out, sdo_oe;
  wire       sda = sda_m & ~sda_oe; // pull-up wins unless someone pulls low
  integer    error_cnt = 0;
  integer    check_count = 0;
  integer    cyc = 0;
  reg  [7:0] rx;
  reg        ack;
  always #2.5 clock = ~clock;
  ssf_top DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .sck_in(sck), .sdi_in(sdi), .ss_n_in(ss_n), .sdo_out(sdo_out), .sdo_oe(sdo_oe));
  ssf_link_master link (.sda(sda), .sdo(sdo_out), .scl(scl), .sda_m(sda_m), .sck(sck), .sdi(sdi), .ss_n(ss_n));
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task cmp(input [79:0] nm, input [7:0] at, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0s at %h expected %h seen %h", nm, at, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      // a spare edge so a following write never sets the strobe again in this step
      @(posedge clock);
    end
  endtask
  // read one register; data stand only at the second edge, compared under mask m
  task rd(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      cmp("reg_rdata", a, e, reg_rdata & m);
    end
  endtask
  // realign to the clock and let the pin filter settle
  task sync;
    repeat (8) @(posedge clock);
  endtask
  // cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(`SSF_OFF_STATUS, 8'hFF, 8'h00);
    wr(`SSF_OFF_STATUS, 8'hFF);
    rd(`SSF_OFF_STATUS, 8'hFF, 8'h00);
    rd(8'h55, 8'hFF, 8'h00);
    // spi receive, event flag, masking and clearing of the interrupt
    wr(`SSF_OFF_CTRL, 8'h20);
    wr(`SSF_OFF_BUF, 8'hA5);
    link.spi_byte(8'h3C, rx);
    cmp("sdo", 8'h00, 8'hA5, rx);
    sync;
    rd(`SSF_OFF_STATUS, 8'hFF, 8'h01);
    rd(`SSF_OFF_IRQ_ST, 8'hFF, 8'h01);
    cmp("irq", 8'h00, 8'h00, {7'h00, irq});
    wr(`SSF_OFF_IRQ_MASK, 8'h01);
    sync;
    cmp("irq", 8'h00, 8'h01, {7'h00, irq});
    rd(`SSF_OFF_BUF, 8'hFF, 8'h3C);
    rd(`SSF_OFF_STATUS, 8'hFF, 8'h00);
    wr(`SSF_OFF_IRQ_ST, 8'h01);
    sync;
    cmp("irq", 8'h00, 8'h00, {7'h00, irq});
    // i2c write transfer: address then data, then stop and disable
    wr(`SSF_OFF_CTRL, 8'h21);
    wr(`SSF_OFF_SADDR, 8'h84);
    link.i2c_start;
    sync;
    rd(`SSF_OFF_STATUS, 8'hFF, 8'h08);
    link.i2c_byte(8'h84, 1'b0, 0, ack, rx);
    sync;
    cmp("ack", 8'h00, 8'h01, {7'h00, ack});
    rd(`SSF_OFF_STATUS, 8'hFF, 8'h09);
    rd(`SSF_OFF_BUF, 8'hFF, 8'h84);
    link.i2c_byte(8'h5A, 1'b0, 0, ack, rx);
    sync;
    rd(`SSF_OFF_STATUS, 8'hFF, 8'h29);
    rd(`SSF_OFF_BUF, 8'hFF, 8'h5A);
    link.i2c_stop;
    sync;
    rd(`SSF_OFF_STATUS, 8'h1F, 8'h10);
    wr(`SSF_OFF_CTRL, 8'h01);
    sync;
    rd(`SSF_OFF_STATUS, 8'h18, 8'h00);
    // i2c read transfer: buffer loaded while the ack clock is held high
    wr(`SSF_OFF_CTRL, 8'h21);
    link.i2c_start;
    fork
      link.i2c_byte(8'h85, 1'b0, 1000, ack, rx);
      begin
        repeat (270) @(posedge clock);
        rd(`SSF_OFF_STATUS, 8'h3D, 8'h0D);
        rd(`SSF_OFF_BUF, 8'hFF, 8'h85);
        wr(`SSF_OFF_BUF, 8'hC3);
        rd(`SSF_OFF_STATUS, 8'h01, 8'h01);
      end
    join
    link.i2c_byte(8'hFF, 1'b0, 0, ack, rx);
    sync;
    cmp("rx", 8'h00, 8'hC3, rx);
    rd(`SSF_OFF_STATUS, 8'h01, 8'h00);
    link.i2c_stop;
    sync;
    rd(`SSF_OFF_STATUS, 8'h1C, 8'h10);
    // ten-bit header match asks for an address rewrite
    wr(`SSF_OFF_CTRL, 8'h23);
    wr(`SSF_OFF_SADDR, 8'hF0);
    link.i2c_start;
    link.i2c_byte(8'hF0, 1'b0, 0, ack, rx);
    sync;
    rd(`SSF_OFF_STATUS, 8'h02, 8'h02);
    wr(`SSF_OFF_SADDR, 8'h34);
    rd(`SSF_OFF_STATUS, 8'h02, 8'h00);
    link.i2c_stop;
    sync;
    wrap_up;
  end
endmodule // test_sync_serial_status_flags
